// [hdl/switch_ingress_cfg_and_dscp_table.sv]
// Switch engine ingress configuration registers and ToS/CS priority table access
`timescale 1ns/1ps
`default_nettype none

module switch_ingress_cfg_and_dscp_table #(
	parameter int DEPTH         = swe_ingress_pkg::TABLE_DEPTH,
	parameter int ACCESS_CYCLES = swe_ingress_pkg::TABLE_ACCESS_CYCLES
) (
	input  wire logic        clk_sys_i,
	input  wire logic        reset_n_i,
	input  wire logic [15:0] reg_addr_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [31:0] reg_wdata_i,
	output logic      [31:0] reg_rdata_o,
	output logic             reg_rvalid_o,
	input  wire logic        vlan_busy_i,
	input  wire logic        pkt_valid_i,
	input  wire logic        pkt_vlan_tagged_i,
	input  wire logic [2:0]  pkt_vlan_prio_i,
	input  wire logic        pkt_is_ipv4_i,
	input  wire logic        pkt_is_ipv6_i,
	input  wire logic [7:0]  pkt_tos_i,
	input  wire logic [2:0]  pkt_default_prio_i,
	input  wire logic        pkt_da_found_i,
	input  wire logic        pkt_da_static_i,
	input  wire logic [2:0]  pkt_da_prio_i,
	input  wire logic        pkt_unicast_i,
	input  wire logic        pkt_multicast_i,
	input  wire logic        pkt_broadcast_i,
	input  wire logic        pkt_igmp_i,
	output logic             dec_valid_o,
	output logic      [2:0]  dec_prio_o,
	output logic             dec_drop_o,
	output logic      [2:0]  dec_igmp_ports_o,
	output logic             cfg_vlan_en_o,
	output logic             cfg_allow_echo_o,
	output logic             cfg_counter_test_o,
	output logic      [31:0] counter_clear_value_o
);

	if (DEPTH != 64 || ACCESS_CYCLES < 1) begin : g_bad_param
		$error("switch_ingress_cfg_and_dscp_table: unsupported parameters");
	end

	localparam int IW = $clog2(DEPTH);
	localparam int PW = swe_ingress_pkg::PRIO_W;

	////////////////////////////////////////////////////////////////////////////////
	// Register file

	logic [31:0]   cfg;
	logic [31:0]   next_cfg;
	logic [31:0]   cmd;
	logic [31:0]   next_cmd;
	logic [31:0]   wdata;
	logic [31:0]   next_wdata;
	logic [31:0]   next_rdata;
	logic [31:0]   next_cnt_value;
	logic          vlan_pend;
	logic          cmd_launch;
	logic          tbl_busy;
	logic [PW-1:0] tbl_rdata;
	logic [PW-1:0] lkp_rdata;

	assign cmd_launch = reg_wr_i && reg_addr_i == swe_ingress_pkg::REG_PT_CMD && !tbl_busy;

	always_comb begin
		next_cfg   = cfg;
		next_cmd   = cmd;
		next_wdata = wdata;
		next_rdata = 32'h0000_0000;
		// Reserved bits held at zero by masks
		if (reg_wr_i) begin
			if (reg_addr_i == swe_ingress_pkg::REG_GLOBAL_CFG) begin
				next_cfg = reg_wdata_i & swe_ingress_pkg::GLOBAL_MASK;
			end else if (cmd_launch) begin
				next_cmd = reg_wdata_i & swe_ingress_pkg::CMD_MASK;
			end else if (reg_addr_i == swe_ingress_pkg::REG_PT_WDATA) begin
				next_wdata = reg_wdata_i & swe_ingress_pkg::WDATA_MASK;
			end
		end
		if (reg_rd_i) begin
			if (reg_addr_i == swe_ingress_pkg::REG_VLAN_STS) begin
				next_rdata[swe_ingress_pkg::PEND_BIT] = vlan_pend;
			end else if (reg_addr_i == swe_ingress_pkg::REG_PT_CMD) begin
				next_rdata = cmd;
			end else if (reg_addr_i == swe_ingress_pkg::REG_PT_WDATA) begin
				next_rdata = wdata;
			end else if (reg_addr_i == swe_ingress_pkg::REG_PT_RDATA) begin
				next_rdata[PW-1:0] = tbl_rdata;
			end else if (reg_addr_i == swe_ingress_pkg::REG_PT_STS) begin
				next_rdata[swe_ingress_pkg::PEND_BIT] = tbl_busy;
			end else if (reg_addr_i == swe_ingress_pkg::REG_GLOBAL_CFG) begin
				next_rdata = cfg;
			end
		end
		next_cnt_value = next_cfg[swe_ingress_pkg::G_CNT_TEST] ?
			swe_ingress_pkg::CNT_TEST_VALUE : swe_ingress_pkg::CNT_CLEAR_VALUE;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			cfg                   <= swe_ingress_pkg::GLOBAL_RESET;
			cmd                   <= 32'h0000_0000;
			wdata                 <= 32'h0000_0000;
			reg_rdata_o           <= 32'h0000_0000;
			reg_rvalid_o          <= 1'b0;
			vlan_pend             <= 1'b0;
			cfg_vlan_en_o         <= 1'b0;
			cfg_allow_echo_o      <= 1'b0;
			cfg_counter_test_o    <= 1'b0;
			counter_clear_value_o <= swe_ingress_pkg::CNT_CLEAR_VALUE;
		end else begin
			cfg                   <= next_cfg;
			cmd                   <= next_cmd;
			wdata                 <= next_wdata;
			reg_rdata_o           <= next_rdata;
			reg_rvalid_o          <= reg_rd_i;
			vlan_pend             <= vlan_busy_i;
			cfg_vlan_en_o         <= next_cfg[swe_ingress_pkg::G_VLAN_EN];
			cfg_allow_echo_o      <= next_cfg[swe_ingress_pkg::G_ECHO];
			cfg_counter_test_o    <= next_cfg[swe_ingress_pkg::G_CNT_TEST];
			counter_clear_value_o <= next_cnt_value;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Priority table

	prio_table_ram #(
		.DEPTH         (DEPTH),
		.WIDTH         (PW),
		.ACCESS_CYCLES (ACCESS_CYCLES)
	) u_table (
		.clk_sys_i   (clk_sys_i),
		.reset_n_i   (reset_n_i),
		.start_i     (cmd_launch),
		.read_i      (reg_wdata_i[swe_ingress_pkg::CMD_DIR_BIT]),
		.index_i     (reg_wdata_i[swe_ingress_pkg::CMD_IDX_MSB:swe_ingress_pkg::CMD_IDX_LSB]),
		.wdata_i     (wdata[PW-1:0]),
		.lkp_index_i (pkt_tos_i[swe_ingress_pkg::TOS_CS_MSB:swe_ingress_pkg::TOS_CS_LSB]),
		.busy_o      (tbl_busy),
		.done_o      (),
		.rdata_o     (tbl_rdata),
		.lkp_rdata_o (lkp_rdata)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Ingress decision pipeline

	logic          s1_valid;
	logic          s1_tagged;
	logic [PW-1:0] s1_vlan_prio;
	logic          s1_ipv4;
	logic          s1_ip;
	logic [7:0]    s1_tos;
	logic [PW-1:0] s1_def_prio;
	logic          s1_da_found;
	logic          s1_da_static;
	logic [PW-1:0] s1_da_prio;
	logic          s1_unicast;
	logic          s1_mcast;
	logic          s1_igmp;
	logic [PW-1:0] next_prio;
	logic          next_drop;
	logic [2:0]    next_igmp_ports;
	logic          ip_ok;
	logic          vlan_ok;

	always_comb begin
		ip_ok   = cfg[swe_ingress_pkg::G_USE_IP] && s1_ip;
		vlan_ok = cfg[swe_ingress_pkg::G_VLAN_EN] && s1_tagged;
		if (cfg[swe_ingress_pkg::G_DA_PRIO] && s1_da_found && s1_da_static) begin
			next_prio = s1_da_prio;
		end else if (vlan_ok && (cfg[swe_ingress_pkg::G_VL_HIGH] || !ip_ok)) begin
			next_prio = s1_vlan_prio;
		end else if (ip_ok && s1_ipv4 && cfg[swe_ingress_pkg::G_USE_PREC]) begin
			next_prio = s1_tos[swe_ingress_pkg::TOS_PREC_MSB:swe_ingress_pkg::TOS_PREC_LSB];
		end else if (ip_ok) begin
			next_prio = lkp_rdata;
		end else begin
			next_prio = s1_def_prio;
		end
		next_drop = s1_valid && !s1_da_found &&
			((cfg[swe_ingress_pkg::G_DROP_UNK] && s1_unicast) ||
			(cfg[swe_ingress_pkg::G_FILT_MC] && s1_mcast));
		next_igmp_ports = (s1_valid && s1_igmp && cfg[swe_ingress_pkg::G_IGMP_EN]) ?
			cfg[swe_ingress_pkg::G_IGMP_MSB:swe_ingress_pkg::G_IGMP_LSB] : 3'h0;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			s1_valid         <= 1'b0;
			s1_tagged        <= 1'b0;
			s1_vlan_prio     <= '0;
			s1_ipv4          <= 1'b0;
			s1_ip            <= 1'b0;
			s1_tos           <= 8'h00;
			s1_def_prio      <= '0;
			s1_da_found      <= 1'b0;
			s1_da_static     <= 1'b0;
			s1_da_prio       <= '0;
			s1_unicast       <= 1'b0;
			s1_mcast         <= 1'b0;
			s1_igmp          <= 1'b0;
			dec_valid_o      <= 1'b0;
			dec_prio_o       <= '0;
			dec_drop_o       <= 1'b0;
			dec_igmp_ports_o <= 3'h0;
		end else begin
			s1_valid         <= pkt_valid_i;
			s1_tagged        <= pkt_vlan_tagged_i;
			s1_vlan_prio     <= pkt_vlan_prio_i;
			s1_ipv4          <= pkt_is_ipv4_i;
			s1_ip            <= pkt_is_ipv4_i || pkt_is_ipv6_i;
			s1_tos           <= pkt_tos_i;
			s1_def_prio      <= pkt_default_prio_i;
			s1_da_found      <= pkt_da_found_i;
			s1_da_static     <= pkt_da_static_i;
			s1_da_prio       <= pkt_da_prio_i;
			s1_unicast       <= pkt_unicast_i;
			s1_mcast         <= pkt_multicast_i && !pkt_broadcast_i;
			s1_igmp          <= pkt_igmp_i;
			dec_valid_o      <= s1_valid;
			dec_prio_o       <= next_prio;
			dec_drop_o       <= next_drop;
			dec_igmp_ports_o <= next_igmp_ports;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);

	logic cfg_wr;
	assign cfg_wr = reg_wr_i && reg_addr_i == swe_ingress_pkg::REG_GLOBAL_CFG;

	property p_launch;
		cmd_launch |=> tbl_busy;
	endproperty
	a_launch: assert property (p_launch) else $error("command write did not launch");

	property p_pend_read;
		reg_rd_i && reg_addr_i == swe_ingress_pkg::REG_PT_STS |=> reg_rvalid_o && reg_rdata_o == {31'h0, $past(tbl_busy)};
	endproperty
	a_pend_read: assert property (p_pend_read) else $error("table pending bit wrong");

	property p_vlan_read;
		reg_rd_i && reg_addr_i == swe_ingress_pkg::REG_VLAN_STS |=> reg_rdata_o == {31'h0, $past(vlan_busy_i, 2)};
	endproperty
	a_vlan_read: assert property (p_vlan_read) else $error("vlan pending bit wrong");

	property p_cmd_rsvd;
		reg_rd_i && reg_addr_i == swe_ingress_pkg::REG_PT_CMD |=> reg_rdata_o[31:8] == 24'h0 && !reg_rdata_o[6];
	endproperty
	a_cmd_rsvd: assert property (p_cmd_rsvd) else $error("reserved command bits set");

	property p_cfg_write;
		cfg_wr |=> cfg_vlan_en_o == $past(reg_wdata_i[0]) && cfg_allow_echo_o == $past(reg_wdata_i[13]);
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("config outputs not updated");

	property p_counter;
		counter_clear_value_o == (cfg_counter_test_o ? 32'h7FFF_FFFC : 32'h0000_0000);
	endproperty
	a_counter: assert property (p_counter) else $error("counter load value wrong");

	property p_drop_unknown;
		pkt_valid_i && pkt_unicast_i && !pkt_da_found_i && cfg[3] && !cfg_wr |-> ##2 dec_drop_o;
	endproperty
	a_drop_unknown: assert property (p_drop_unknown) else $error("unknown unicast not dropped");

	property p_prec;
		pkt_valid_i && pkt_is_ipv4_i && !pkt_vlan_tagged_i && !pkt_da_static_i && cfg[9] && cfg[2] && !cfg_wr
			|-> ##2 dec_prio_o == $past(pkt_tos_i[7:5], 2);
	endproperty
	a_prec: assert property (p_prec) else $error("precedence priority wrong");

	property p_igmp;
		pkt_valid_i && pkt_igmp_i && cfg[7] && !cfg_wr |-> ##2 dec_igmp_ports_o == $past(cfg[12:10]);
	endproperty
	a_igmp: assert property (p_igmp) else $error("igmp not redirected");

	property p_igmp_idle;
		!dec_valid_o |-> dec_igmp_ports_o == 3'h0 && !dec_drop_o;
	endproperty
	a_igmp_idle: assert property (p_igmp_idle) else $error("decision active without valid");

	property p_da_prio;
		pkt_valid_i && pkt_da_found_i && pkt_da_static_i && cfg[swe_ingress_pkg::G_DA_PRIO] && !cfg_wr
			|-> ##2 dec_prio_o == $past(pkt_da_prio_i, 2);
	endproperty
	a_da_prio: assert property (p_da_prio) else $error("static entry priority wrong");

	property p_vlan_first;
		pkt_valid_i && pkt_vlan_tagged_i && !pkt_da_static_i && !cfg_wr &&
			cfg[swe_ingress_pkg::G_VLAN_EN] && cfg[swe_ingress_pkg::G_VL_HIGH]
			|-> ##2 dec_prio_o == $past(pkt_vlan_prio_i, 2);
	endproperty
	a_vlan_first: assert property (p_vlan_first) else $error("vlan priority not first");

	property p_mcast_drop;
		pkt_valid_i && pkt_multicast_i && !pkt_broadcast_i && !pkt_da_found_i &&
			cfg[swe_ingress_pkg::G_FILT_MC] && !cfg_wr |-> ##2 dec_drop_o;
	endproperty
	a_mcast_drop: assert property (p_mcast_drop) else $error("unknown multicast not dropped");

	property p_bcast_keep;
		pkt_valid_i && pkt_broadcast_i && !pkt_unicast_i |-> ##2 !dec_drop_o;
	endproperty
	a_bcast_keep: assert property (p_bcast_keep) else $error("broadcast dropped");

	property p_no_ip;
		pkt_valid_i && !cfg[swe_ingress_pkg::G_USE_IP] && !cfg[swe_ingress_pkg::G_VLAN_EN] &&
			!cfg[swe_ingress_pkg::G_DA_PRIO] && !cfg_wr
			|-> ##2 dec_prio_o == $past(pkt_default_prio_i, 2);
	endproperty
	a_no_ip: assert property (p_no_ip) else $error("default priority not used");

	property p_cfg_rsvd;
		reg_rd_i && reg_addr_i == swe_ingress_pkg::REG_GLOBAL_CFG |=> reg_rdata_o[31:14] == 18'h0 && !reg_rdata_o[8];
	endproperty
	a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("reserved config bits set");

	c_read_cmd: cover property (cmd_launch && reg_wdata_i[7] ##[1:20] !tbl_busy);
	c_write_cmd: cover property (cmd_launch && !reg_wdata_i[7] ##[1:20] !tbl_busy);
	c_igmp: cover property (dec_valid_o && dec_igmp_ports_o != 3'h0);
	c_drop: cover property (dec_valid_o && dec_drop_o);

endmodule

`default_nettype wire

// [hdl/swe_ingress_pkg.sv]
// Register numbers, field positions and constants for the ingress config slice
package swe_ingress_pkg;

	// Register numbers
	localparam logic [15:0] REG_VLAN_STS   = 16'h1810;
	localparam logic [15:0] REG_PT_CMD     = 16'h1811;
	localparam logic [15:0] REG_PT_WDATA   = 16'h1812;
	localparam logic [15:0] REG_PT_RDATA   = 16'h1813;
	localparam logic [15:0] REG_PT_STS     = 16'h1814;
	localparam logic [15:0] REG_GLOBAL_CFG = 16'h1840;

	// Command register fields
	localparam int CMD_DIR_BIT = 7;
	localparam int CMD_IDX_MSB = 5;
	localparam int CMD_IDX_LSB = 0;
	localparam int PEND_BIT    = 0;
	localparam int PRIO_W      = 3;

	// Writable masks and reset values
	localparam logic [31:0] CMD_MASK       = 32'h0000_00BF;
	localparam logic [31:0] WDATA_MASK     = 32'h0000_0007;
	localparam logic [31:0] GLOBAL_MASK    = 32'h0000_3EFF;
	localparam logic [31:0] GLOBAL_RESET   = 32'h0000_0006;
	localparam logic [31:0] CNT_TEST_VALUE = 32'h7FFF_FFFC;
	localparam logic [31:0] CNT_CLEAR_VALUE = 32'h0000_0000;

	// Global ingress fields
	localparam int G_ECHO     = 13;
	localparam int G_IGMP_MSB = 12;
	localparam int G_IGMP_LSB = 10;
	localparam int G_USE_IP   = 9;
	localparam int G_IGMP_EN  = 7;
	localparam int G_CNT_TEST = 6;
	localparam int G_DA_PRIO  = 5;
	localparam int G_FILT_MC  = 4;
	localparam int G_DROP_UNK = 3;
	localparam int G_USE_PREC = 2;
	localparam int G_VL_HIGH  = 1;
	localparam int G_VLAN_EN  = 0;

	// ToS octet fields
	localparam int TOS_PREC_MSB = 7;
	localparam int TOS_PREC_LSB = 5;
	localparam int TOS_CS_MSB   = 7;
	localparam int TOS_CS_LSB   = 2;

	// Table geometry and access time
	localparam int TABLE_DEPTH         = 64;
	localparam int TABLE_ACCESS_CYCLES = 2;

endpackage

// [hdl/prio_table_ram.sv]
// ToS/CS to priority table with a host access sequencer and a lookup read port
`timescale 1ns/1ps
`default_nettype none

module prio_table_ram #(
	parameter int DEPTH         = 64,
	parameter int WIDTH         = 3,
	parameter int ACCESS_CYCLES = 2,
	parameter int IW            = $clog2(DEPTH)
) (
	input  wire logic             clk_sys_i,
	input  wire logic             reset_n_i,
	input  wire logic             start_i,
	input  wire logic             read_i,
	input  wire logic [IW-1:0]    index_i,
	input  wire logic [WIDTH-1:0] wdata_i,
	input  wire logic [IW-1:0]    lkp_index_i,
	output logic                  busy_o,
	output logic                  done_o,
	output logic [WIDTH-1:0]      rdata_o,
	output logic [WIDTH-1:0]      lkp_rdata_o
);

	if (DEPTH < 2 || ACCESS_CYCLES < 1 || ACCESS_CYCLES > 255) begin : g_bad_param
		$error("prio_table_ram: unsupported parameters");
	end

	typedef enum logic {ST_IDLE, ST_ACCESS} state_t;

	// Contents are never reset
	logic [WIDTH-1:0] mem [DEPTH];

	state_t           state;
	state_t           next_state;
	logic [7:0]       count;
	logic [7:0]       next_count;
	logic             op_read;
	logic             next_op_read;
	logic [IW-1:0]    idx;
	logic [IW-1:0]    next_idx;
	logic [WIDTH-1:0] wd;
	logic [WIDTH-1:0] next_wd;
	logic [WIDTH-1:0] next_rdata;
	logic             next_done;
	logic             mem_we;

	always_comb begin
		next_state   = state;
		next_count   = count;
		next_op_read = op_read;
		next_idx     = idx;
		next_wd      = wd;
		next_rdata   = rdata_o;
		next_done    = 1'b0;
		mem_we       = 1'b0;
		case (state)
			ST_IDLE: begin
				if (start_i) begin
					next_state   = ST_ACCESS;
					next_count   = 8'(ACCESS_CYCLES - 1);
					next_op_read = read_i;
					next_idx     = index_i;
					next_wd      = wdata_i;
				end
			end
			ST_ACCESS: begin
				if (count == 8'h00) begin
					next_state = ST_IDLE;
					next_done  = 1'b1;
					if (op_read) begin
						next_rdata = mem[idx];
					end else begin
						mem_we = 1'b1;
					end
				end else begin
					next_count = count - 8'h01;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			state       <= ST_IDLE;
			count       <= 8'h00;
			op_read     <= 1'b0;
			idx         <= '0;
			wd          <= '0;
			rdata_o     <= '0;
			done_o      <= 1'b0;
			busy_o      <= 1'b0;
			lkp_rdata_o <= '0;
		end else begin
			state       <= next_state;
			count       <= next_count;
			op_read     <= next_op_read;
			idx         <= next_idx;
			wd          <= next_wd;
			rdata_o     <= next_rdata;
			done_o      <= next_done;
			busy_o      <= (next_state == ST_ACCESS);
			lkp_rdata_o <= mem[lkp_index_i];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (mem_we) begin
			mem[idx] <= wd;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);

	property p_wr_store;
		state == ST_ACCESS && count == 8'h00 && !op_read |=> mem[$past(idx)] == $past(wd);
	endproperty
	a_wr_store: assert property (p_wr_store) else $error("table write not stored");

	property p_rd_return;
		state == ST_ACCESS && count == 8'h00 && op_read |=> done_o && rdata_o == mem[$past(idx)];
	endproperty
	a_rd_return: assert property (p_rd_return) else $error("table read data wrong");

	// Length of the current busy run, so a stuck access is caught
	logic [8:0] busy_run;
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i || !busy_o) begin
			busy_run <= 9'h000;
		end else begin
			busy_run <= busy_run + 9'h001;
		end
	end

	property p_busy_bound;
		busy_o |-> busy_run < 9'(ACCESS_CYCLES);
	endproperty
	a_busy_bound: assert property (p_busy_bound) else $error("access ran too long");

endmodule

`default_nettype wire

// [dv/testbench.sv]
// Self-checking testbench for the ingress config registers and priority table
`timescale 1ns/1ps
`default_nettype none

module testbench;

	////////////////////////////////////////////////////////////////////////
	logic        clk_sys_i          = 1'b0;
	logic        reset_n_i          = 1'b0;
	logic [15:0] reg_addr_i         = 16'h0000;
	logic        reg_wr_i           = 1'b0;
	logic        reg_rd_i           = 1'b0;
	logic [31:0] reg_wdata_i        = 32'h0000_0000;
	logic        vlan_busy_i        = 1'b0;
	logic        pkt_valid_i        = 1'b0;
	logic [8:0]  pf                 = 9'h000;
	logic [2:0]  pkt_vlan_prio_i    = 3'h0;
	logic [7:0]  pkt_tos_i          = 8'h00;
	logic [31:0] reg_rdata_o;
	logic        reg_rvalid_o;
	logic        dec_valid_o;
	logic [2:0]  dec_prio_o;
	logic        dec_drop_o;
	logic [2:0]  dec_igmp_ports_o;
	logic        cfg_vlan_en_o;
	logic        cfg_allow_echo_o;
	logic        cfg_counter_test_o;
	logic [31:0] counter_clear_value_o;
	int          err_total          = 0;
	int          cmp_count          = 0;

	always #2.5 clk_sys_i = ~clk_sys_i;

	switch_ingress_cfg_and_dscp_table DUT (
		.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
		.vlan_busy_i(vlan_busy_i), .pkt_valid_i(pkt_valid_i), .pkt_vlan_tagged_i(pf[8]),
		.pkt_vlan_prio_i(pkt_vlan_prio_i), .pkt_is_ipv4_i(pf[7]), .pkt_is_ipv6_i(pf[6]), .pkt_tos_i(pkt_tos_i),
		.pkt_default_prio_i(3'h2), .pkt_da_found_i(pf[5]), .pkt_da_static_i(pf[4]), .pkt_da_prio_i(3'h1),
		.pkt_unicast_i(pf[3]), .pkt_multicast_i(pf[2]), .pkt_broadcast_i(pf[1]), .pkt_igmp_i(pf[0]),
		.dec_valid_o(dec_valid_o), .dec_prio_o(dec_prio_o), .dec_drop_o(dec_drop_o),
		.dec_igmp_ports_o(dec_igmp_ports_o), .cfg_vlan_en_o(cfg_vlan_en_o), .cfg_allow_echo_o(cfg_allow_echo_o),
		.cfg_counter_test_o(cfg_counter_test_o), .counter_clear_value_o(counter_clear_value_o)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t register value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_dec(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t decision %h expected %h", $time, got, exp);
		end
	endtask

	task automatic reg_write(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		reg_wr_i    <= 1'b1;
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask

	// Answer counts only with its valid flag
	task automatic reg_read(input logic [15:0] a, output logic [31:0] d);
		@(posedge clk_sys_i);
		reg_rd_i   <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		#1;
		d = (reg_rvalid_o === 1'b1) ? reg_rdata_o : 32'hXXXX_XXXX;
	endtask

	task automatic reg_check(input logic [15:0] a, input logic [31:0] exp);
		logic [31:0] d;
		reg_read(a, d);
		chk_reg(d, exp);
	endtask

	task automatic wait_idle();
		logic [31:0] d;
		d = 32'h0000_0001;
		for (int i = 0; i < 16 && d !== 32'h0000_0000; i++) begin
			reg_read(swe_ingress_pkg::REG_PT_STS, d);
		end
		chk_reg(d, 32'h0000_0000);
	endtask

	// Data first, then command, then poll
	task automatic table_write(input logic [5:0] idx, input logic [31:0] v);
		reg_write(swe_ingress_pkg::REG_PT_WDATA, v);
		reg_write(swe_ingress_pkg::REG_PT_CMD, {26'h0, idx});
		wait_idle();
	endtask

	task automatic table_read(input logic [5:0] idx, input logic [31:0] exp);
		reg_write(swe_ingress_pkg::REG_PT_CMD, {24'h0, 2'h2, idx});
		reg_check(swe_ingress_pkg::REG_PT_STS, 32'h0000_0001);
		wait_idle();
		reg_check(swe_ingress_pkg::REG_PT_RDATA, exp);
	endtask

	// Exp is {drop, igmp ports, prio}; answer lands two cycles after the pulse
	task automatic dec(input logic [31:0] cfg, input logic [8:0] f, input logic [2:0] vp,
	                   input logic [7:0] tos, input logic [6:0] exp);
		reg_write(swe_ingress_pkg::REG_GLOBAL_CFG, cfg);
		@(posedge clk_sys_i);
		pkt_valid_i     <= 1'b1;
		pf              <= f;
		pkt_vlan_prio_i <= vp;
		pkt_tos_i       <= tos;
		@(posedge clk_sys_i);
		pkt_valid_i <= 1'b0;
		#1;
		chk_dec({7'h00, dec_valid_o}, 8'h00);
		@(posedge clk_sys_i);
		#1;
		chk_dec({dec_valid_o, dec_drop_o, dec_igmp_ports_o, dec_prio_o}, {1'b1, exp});
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		err_total++;
		end_sim();
	end

	initial begin
		repeat (8) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		// Reset values and an unmapped number
		reg_check(16'h1810, 32'h0000_0000);
		reg_check(16'h1811, 32'h0000_0000);
		reg_check(16'h1812, 32'h0000_0000);
		reg_check(16'h1813, 32'h0000_0000);
		reg_check(16'h1814, 32'h0000_0000);
		reg_check(16'h1840, 32'h0000_0006);
		reg_check(16'h1820, 32'h0000_0000);
		chk_reg({29'h0, cfg_vlan_en_o, cfg_allow_echo_o, cfg_counter_test_o}, 32'h0000_0000);
		// Read-only places and reserved bits
		reg_write(16'h1810, 32'hFFFF_FFFF);
		reg_check(16'h1810, 32'h0000_0000);
		reg_write(16'h1814, 32'hFFFF_FFFF);
		reg_check(16'h1814, 32'h0000_0000);
		reg_write(16'h1840, 32'hFFFF_FFFF);
		reg_check(16'h1840, 32'h0000_3EFF);
		// VLAN engine busy flag follows the engine
		@(posedge clk_sys_i);
		vlan_busy_i <= 1'b1;
		reg_check(16'h1810, 32'h0000_0001);
		@(posedge clk_sys_i);
		vlan_busy_i <= 1'b0;
		@(posedge clk_sys_i);
		reg_check(16'h1810, 32'h0000_0000);
		// Table programming, boundary indices
		table_write(6'd0, 32'hFFFF_FFFB);
		reg_check(16'h1812, 32'h0000_0003);
		table_write(6'd21, 32'h0000_0005);
		table_write(6'd63, 32'h0000_0006);
		reg_check(16'h1811, 32'h0000_003F);
		table_read(6'd0, 32'h0000_0003);
		table_read(6'd63, 32'h0000_0006);
		table_read(6'd21, 32'h0000_0005);
		// All-ones command reads entry 63, reserved bits dropped
		reg_write(16'h1811, 32'hFFFF_FFFF);
		wait_idle();
		reg_check(16'h1811, 32'h0000_00BF);
		reg_check(16'h1813, 32'h0000_0006);
		// Command during an access is dropped
		reg_write(16'h1811, 32'h0000_0080);
		reg_write(16'h1811, 32'h0000_0015);
		wait_idle();
		reg_check(16'h1811, 32'h0000_0080);
		reg_check(16'h1813, 32'h0000_0003);
		table_read(6'd21, 32'h0000_0005);
		// Exported configuration copies
		reg_write(16'h1840, 32'h0000_2041);
		@(posedge clk_sys_i);
		#1;
		chk_reg({29'h0, cfg_vlan_en_o, cfg_allow_echo_o, cfg_counter_test_o}, 32'h0000_0007);
		chk_reg(counter_clear_value_o, 32'h7FFF_FFFC);
		reg_write(16'h1840, 32'h0000_0000);
		@(posedge clk_sys_i);
		#1;
		chk_reg(counter_clear_value_o, 32'h0000_0000);
		// Priority source selection
		dec(32'h0000_0006, 9'h080, 3'h0, 8'hA0, 7'h02);
		dec(32'h0000_0207, 9'h180, 3'h4, 8'hE0, 7'h04);
		dec(32'h0000_0205, 9'h180, 3'h4, 8'hE0, 7'h07);
		dec(32'h0000_0201, 9'h080, 3'h0, 8'h54, 7'h05);
		dec(32'h0000_0205, 9'h040, 3'h0, 8'hFC, 7'h06);
		dec(32'h0000_0225, 9'h1B0, 3'h4, 8'hE0, 7'h01);
		dec(32'h0000_0001, 9'h100, 3'h4, 8'h00, 7'h04);
		dec(32'h0000_0000, 9'h100, 3'h4, 8'h00, 7'h02);
		// Unknown destination filtering
		dec(32'h0000_0018, 9'h008, 3'h0, 8'h00, 7'h42);
		dec(32'h0000_0018, 9'h004, 3'h0, 8'h00, 7'h42);
		dec(32'h0000_0018, 9'h006, 3'h0, 8'h00, 7'h02);
		dec(32'h0000_0018, 9'h028, 3'h0, 8'h00, 7'h02);
		dec(32'h0000_0000, 9'h008, 3'h0, 8'h00, 7'h02);
		dec(32'h0000_0008, 9'h004, 3'h0, 8'h00, 7'h02);
		// IGMP redirection
		dec(32'h0000_1480, 9'h081, 3'h0, 8'h00, 7'h2A);
		dec(32'h0000_1400, 9'h081, 3'h0, 8'h00, 7'h02);
		end_sim();
	end

endmodule

`default_nettype wire
